//--- shared/cfs_cfg.svh
// Constants of the configuration front end: timing, addresses, fields, map.
// Assumes a 125 MHz system clock and 32-bit Avalon-MM register access.
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH
// System clock and generated configuration clock rates in Hz
`define CFS_CLK_HZ 125000000
`define CFS_SLOW_HZ 1000000
`define CFS_FAST_HZ 8000000
// Half periods of the generated clock in system cycles, rounded down
`define CFS_SLOW_HALF 7'((`CFS_CLK_HZ / `CFS_SLOW_HZ) / 2)
`define CFS_FAST_HALF 7'((`CFS_CLK_HZ / `CFS_FAST_HZ) / 2)
// PROM start addresses for the two parallel master variants
`define CFS_ADDR_UP_START 18'h00000
`define CFS_ADDR_DN_START 18'h3ffff
// Length count field width and the bit count that marks it loaded
`define CFS_LEN_W 24
`define CFS_LEN_LOADED 5'h18
// Register byte offsets
`define CFS_REG_CTRL 4'h0
`define CFS_REG_STATUS 4'h4
`define CFS_REG_COUNT 4'h8
`define CFS_REG_LENGTH 4'hc
// Control register reset value and field positions
`define CFS_CTRL_RST 10'h1a0
`define CFS_C_FAST 0
`define CFS_C_UCLK 1
`define CFS_C_DSYNC 2
`define CFS_C_DTAP 3
`define CFS_C_ITAP 5
`define CFS_C_GTAP 7
`define CFS_C_MIDOUT 9
// Positions in the vector of synchronised pins
`define CFS_S_MODE 0
`define CFS_S_CONFIG_CLOCK 3
`define CFS_S_DIN 4
`define CFS_S_DATA 5
`define CFS_S_WR 13
`define CFS_S_INIT 14
`define CFS_S_DONE 15
`define CFS_S_UCLK 16
`define CFS_S_W 17
`endif

//--- shared/cfs_pkg.sv
// Types of the configuration front end: mode codes and sequence phases.
// Assumes the constants of cfs_cfg.svh; holds no logic.
package cfs_pkg;
  // Mode code from the three mode pins, high pin first
  typedef enum logic [2:0] {
    CFS_M_MSER = 3'h0,
    CFS_M_RSVD = 3'h1,
    CFS_M_EXPR = 3'h2,
    CFS_M_PSYN = 3'h3,
    CFS_M_PUP = 3'h4,
    CFS_M_PASY = 3'h5,
    CFS_M_PDN = 3'h6,
    CFS_M_SSER = 3'h7
  } cfs_mode_t;
  // Phases of the load and start-up sequence
  typedef enum logic [1:0] {CFS_IDLE, CFS_LOAD, CFS_START, CFS_USER} cfs_phase_t;
endpackage : cfs_pkg

//--- hdl/cfs_loader.sv
// Configuration loader: mode decode, clocking, length count, start-up.
// Assumes pins arrive asynchronously and software uses Avalon-MM.
//
// Notes on behaviour
// - Decode three mode pins; some modes drive clock
// - Parallel master: clock, PROM address up/down, serialize
// - Serial master: drive clock, take serial bits
// - Clock starts slow, may go fast first frame
// - Peripheral modes take host bytes, ready/busy handshake
// - Async peripheral: clock burst per byte
// - Start-up when full and count equals length
// - Next edge sets stage a; taps time events
// - Done-synced options gate stage d on pin
// - Later stages clocked by config or user clock
// - Config clock start-up: early done, late reset
// - User clock: stage b bridges the clocks
// - Held-low done pin stalls start-up
// - Non-express modes load length, count clocks
// - Done only when full and count exact
// - Counter starts at very first clock
// - Master mismatch keeps clocking through wrap
// - Express: no length, done when data complete
// - Mode pins sampled first, then user pins
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "cfs_cfg.svh"
module cfs_loader #(
  parameter int MEM_BITS = 1024
) (
  // System clock and synchronous active-low reset
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  // Mode pins
  input wire logic I_MODE_SELECT_HI,
  input wire logic I_MODE_SELECT_MID,
  input wire logic I_MODE_SELECT_LO,
  // Configuration clock pin
  input wire logic I_CONFIG_CLOCK,
  output logic O_CONFIG_CLOCK,
  output logic O_CONFIG_CLOCK_OE_B,
  // Data in: serial bit, byte bus, host write strobe, init level
  input wire logic I_DIN,
  input wire logic [7:0] I_DATA,
  input wire logic I_HOST_WR,
  input wire logic I_INIT,
  // PROM address and ready/busy handshake
  output logic [17:0] O_ADDR,
  output logic O_READY_BUSY,
  // Open-drain completion pin
  input wire logic I_DONE,
  output logic O_DONE,
  output logic O_DONE_OE_B,
  // Start-up clock and start-up results
  input wire logic I_USER_STARTUP_CLOCK,
  output logic O_IO_ACTIVE,
  output logic O_GSR,
  // Middle mode pin as user output after start-up
  output logic O_USER_MID,
  output logic O_USER_MID_OE_B,
  // Avalon-MM slave
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST
);
  localparam int MW = $clog2(MEM_BITS + 1);
  localparam logic [MW-1:0] MEM_FULL = MW'(MEM_BITS);

  // Refuse a memory size below one bit
  if (MEM_BITS < 1) begin : g_chk
    $error("MEM_BITS must be at least one");
  end

  // Whole state of the block
  typedef struct packed {
    logic [`CFS_S_W-1:0] sync1; // First synchroniser stage
    logic [`CFS_S_W-1:0] sync2; // Second synchroniser stage
    logic config_clock_q; // Previous synced clock level
    logic wr_q; // Previous synced write strobe
    logic init_q; // Previous synced init level
    logic uclk_q; // Previous synced user clock
    cfs_pkg::cfs_mode_t mode; // Latched mode
    cfs_pkg::cfs_phase_t phase; // Sequence phase
    logic [6:0] div; // Clock divider
    logic config_clock_o; // Generated clock level
    logic config_clock_oe_b; // Clock pin drive enable, low drives
    logic [6:0] hi_run; // Checker aid: cycles the generated clock has stood high
    logic [`CFS_LEN_W-1:0] cnt; // Clock counter
    logic [`CFS_LEN_W-1:0] len; // Loaded length count
    logic [4:0] lbits; // Length bits taken
    logic [MW-1:0] nbits; // Memory bits taken
    logic [7:0] shreg; // Byte being serialised
    logic [2:0] bidx; // Bit position in byte
    logic full; // Byte pending
    logic [17:0] addr; // PROM address
    logic rdy; // Ready for a host byte
    logic [4:0] stage; // Start-up shift register
    logic done_oe_b; // Done pin pull-down, low pulls
    logic io_act; // User I/O active
    logic gsr; // Global set/reset held
    logic mid_o; // User level on middle mode pin
    logic mid_oe_b; // Middle pin drive enable
    logic [9:0] ctl; // Control register
    logic waitreq; // Avalon wait request
    logic [31:0] rdata; // Avalon read data
  } cfs_state_t;

  cfs_state_t s; // Registered state
  cfs_state_t n; // Next state

  // Synchronised pin views, read from the second stage only
  logic [2:0] mode_s;
  logic config_clock_s, din_s, wr_s, init_s, done_s, uclk_s;
  logic [7:0] data_s;
  assign mode_s = s.sync2[`CFS_S_MODE +: 3];
  assign config_clock_s = s.sync2[`CFS_S_CONFIG_CLOCK];
  assign din_s = s.sync2[`CFS_S_DIN];
  assign data_s = s.sync2[`CFS_S_DATA +: 8];
  assign wr_s = s.sync2[`CFS_S_WR];
  assign init_s = s.sync2[`CFS_S_INIT];
  assign done_s = s.sync2[`CFS_S_DONE];
  assign uclk_s = s.sync2[`CFS_S_UCLK];

  // Mode classes
  logic drives, serial, periph, expr, mem_full, go;
  always_comb begin
    drives = s.mode inside {cfs_pkg::CFS_M_MSER, cfs_pkg::CFS_M_PUP,
                            cfs_pkg::CFS_M_PDN, cfs_pkg::CFS_M_PASY};
    serial = s.mode inside {cfs_pkg::CFS_M_MSER, cfs_pkg::CFS_M_SSER};
    periph = s.mode inside {cfs_pkg::CFS_M_PSYN, cfs_pkg::CFS_M_PASY,
                            cfs_pkg::CFS_M_EXPR};
    expr = s.mode == cfs_pkg::CFS_M_EXPR;
    mem_full = s.nbits == MEM_FULL;
    go = mem_full && (expr || s.cnt == s.len);
  end

  // Next-state logic
  always_comb begin
    logic run, rise, fall, adv, bit_v, bit_d, wr_rise;
    logic [6:0] half;
    n = s;
    run = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    adv = 1'b0;
    bit_v = 1'b0;
    bit_d = 1'b0;
    half = `CFS_SLOW_HALF;
    // Pins enter the two-stage synchroniser
    n.sync1 = {I_USER_STARTUP_CLOCK, I_DONE, I_INIT, I_HOST_WR, I_DATA, I_DIN,
               I_CONFIG_CLOCK, I_MODE_SELECT_HI, I_MODE_SELECT_MID, I_MODE_SELECT_LO};
    n.sync2 = s.sync1;
    n.config_clock_q = config_clock_s;
    n.wr_q = wr_s;
    n.init_q = init_s;
    n.uclk_q = uclk_s;
    wr_rise = wr_s && !s.wr_q;
    // Fast rate only once the length count has been loaded
    if (s.ctl[`CFS_C_FAST] && s.lbits == `CFS_LEN_LOADED) begin
      half = `CFS_FAST_HALF;
    end
    // Clock runs through load and start-up; async mode in bursts, and through a config-clock start-up
    if (s.mode == cfs_pkg::CFS_M_PASY) begin
      run = s.full || s.config_clock_o ||
            (s.phase == cfs_pkg::CFS_START && !s.ctl[`CFS_C_UCLK]);
    end else begin
      run = s.phase == cfs_pkg::CFS_LOAD || s.phase == cfs_pkg::CFS_START;
    end
    if (drives) begin
      // Own divider makes the configuration clock
      if (run && s.div == 7'h00) begin
        n.config_clock_o = !s.config_clock_o;
        n.div = half - 7'h01;
        rise = !s.config_clock_o;
        fall = s.config_clock_o;
      end else if (s.div != 7'h00) begin
        n.div = s.div - 7'h01;
      end
    end else begin
      // Configuration clock comes in on the pin
      rise = config_clock_s && !s.config_clock_q;
    end
    n.config_clock_oe_b = !(drives && s.phase != cfs_pkg::CFS_IDLE &&
                    s.phase != cfs_pkg::CFS_USER);
    // Checker aid: length of the high phase in progress, saturating
    if (!s.config_clock_o) begin
      n.hi_run = 7'h00;
    end else if (s.hi_run != 7'h7f) begin
      n.hi_run = s.hi_run + 7'h01;
    end
    // Start-up stages after a advance on the chosen clock
    adv = s.ctl[`CFS_C_UCLK] ? (uclk_s && !s.uclk_q) : rise;
    case (s.phase)
      cfs_pkg::CFS_IDLE: begin
        // Init going high starts a load with the mode pins sampled
        if (init_s && !s.init_q) begin
          n.mode = cfs_pkg::cfs_mode_t'(mode_s);
          n.phase = cfs_pkg::CFS_LOAD;
          n.cnt = '0;
          n.len = '0;
          n.lbits = '0;
          n.nbits = '0;
          n.full = 1'b0;
          n.bidx = 3'h0;
          n.rdy = 1'b1;
          n.div = 7'h00;
          n.addr = (cfs_pkg::cfs_mode_t'(mode_s) == cfs_pkg::CFS_M_PDN) ?
                   `CFS_ADDR_DN_START : `CFS_ADDR_UP_START;
        end
      end
      cfs_pkg::CFS_LOAD: begin
        // Master parallel fetches the next byte on the falling edge
        if (fall && !s.full &&
            (s.mode == cfs_pkg::CFS_M_PUP || s.mode == cfs_pkg::CFS_M_PDN)) begin
          n.shreg = data_s;
          n.full = 1'b1;
          n.bidx = 3'h0;
          n.addr = (s.mode == cfs_pkg::CFS_M_PUP) ? s.addr + 18'h00001
                                                   : s.addr - 18'h00001;
        end
        // Host byte taken only while ready
        if (periph && s.rdy && wr_rise && !s.full) begin
          n.shreg = data_s;
          n.full = 1'b1;
          n.rdy = 1'b0;
          n.bidx = 3'h0;
        end
        if (rise && go) begin
          n.stage = 5'h01;
          n.phase = cfs_pkg::CFS_START;
        end else if (rise) begin
          n.cnt = s.cnt + 24'h000001;
          if (serial) begin
            bit_v = 1'b1;
            bit_d = din_s;
          end else if (s.full) begin
            bit_v = 1'b1;
            bit_d = s.shreg[7];
            n.shreg = {s.shreg[6:0], 1'b0};
            n.bidx = s.bidx + 3'h1;
            if (s.bidx == 3'h7) begin
              n.full = 1'b0;
              n.rdy = periph;
            end
          end
          if (bit_v) begin
            if (!expr && s.lbits != `CFS_LEN_LOADED) begin
              n.len = {s.len[`CFS_LEN_W-2:0], bit_d};
              n.lbits = s.lbits + 5'h01;
            end else if (!mem_full) begin
              n.nbits = s.nbits + MW'(1);
            end
          end
        end
      end
      cfs_pkg::CFS_START: begin
        n.rdy = 1'b0;
        if (adv) begin
          // Stage b is the crossing from config to user clock
          n.stage[1] = s.stage[0];
          n.stage[2] = s.stage[1];
          // Done-synced options hold stage d until the pin reads high
          if (!s.ctl[`CFS_C_DSYNC] || done_s) begin
            n.stage[3] = s.stage[2];
            n.stage[4] = s.stage[3];
          end
        end
        if (s.stage[4]) begin
          n.phase = cfs_pkg::CFS_USER;
        end
      end
      cfs_pkg::CFS_USER: begin
        // Middle mode pin now serves the design
        n.mid_o = s.ctl[`CFS_C_MIDOUT];
        n.mid_oe_b = 1'b0;
      end
      default: begin
        n.phase = cfs_pkg::CFS_IDLE;
      end
    endcase
    // Taps select which stage triggers each event
    n.done_oe_b = s.stage[3'({1'b0, s.ctl[`CFS_C_DTAP +: 2]}) + 3'h1];
    n.io_act = s.stage[3'({1'b0, s.ctl[`CFS_C_ITAP +: 2]}) + 3'h1];
    n.gsr = !s.stage[3'({1'b0, s.ctl[`CFS_C_GTAP +: 2]}) + 3'h1];
    // Avalon slave: one wait cycle, then answer
    n.waitreq = !((I_AVS_READ || I_AVS_WRITE) && s.waitreq);
    if ((I_AVS_READ || I_AVS_WRITE) && s.waitreq) begin
      case (I_AVS_ADDRESS)
        `CFS_REG_CTRL: n.rdata = {22'h000000, s.ctl};
        `CFS_REG_STATUS: n.rdata = {18'h00000, s.sync2[`CFS_S_MODE],
                                   s.sync2[`CFS_S_MODE + 2], s.io_act, mem_full,
                                   s.rdy, done_s, s.stage, 3'(s.mode)};
        `CFS_REG_COUNT: n.rdata = {8'h00, s.cnt};
        `CFS_REG_LENGTH: n.rdata = {8'h00, s.len};
        default: n.rdata = 32'h00000000;
      endcase
    end
    if (I_AVS_WRITE && !s.waitreq && I_AVS_ADDRESS == `CFS_REG_CTRL) begin
      n.ctl = I_AVS_WRITEDATA[9:0];
    end
    // Synchronous reset to a quiet, unconfigured device
    if (!I_RST_B) begin
      n = '0;
      n.phase = cfs_pkg::CFS_IDLE;
      n.config_clock_oe_b = 1'b1;
      n.gsr = 1'b1;
      n.mid_oe_b = 1'b1;
      n.ctl = `CFS_CTRL_RST;
      n.waitreq = 1'b1;
    end
  end

  // State register
  always_ff @(posedge I_CLOCK) begin
    s <= n;
  end

  // Outputs straight from the state register, except the done level tied low
  assign O_CONFIG_CLOCK = s.config_clock_o;
  assign O_CONFIG_CLOCK_OE_B = s.config_clock_oe_b;
  assign O_ADDR = s.addr;
  assign O_READY_BUSY = s.rdy;
  assign O_DONE = 1'b0;
  assign O_DONE_OE_B = s.done_oe_b;
  assign O_IO_ACTIVE = s.io_act;
  assign O_GSR = s.gsr;
  assign O_USER_MID = s.mid_o;
  assign O_USER_MID_OE_B = s.mid_oe_b;
  assign O_AVS_READDATA = s.rdata;
  assign O_AVS_WAITREQUEST = s.waitreq;

  // Checks
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);

  property p_clk_drive;
    s.phase == cfs_pkg::CFS_LOAD |=> (O_CONFIG_CLOCK_OE_B == !drives);
  endproperty
  a_clk_drive: assert property (p_clk_drive) else $error("clock drive mismatch");

  property p_addr_step;
    s.phase == cfs_pkg::CFS_LOAD && $past(s.phase) == cfs_pkg::CFS_LOAD &&
    $changed(O_ADDR) |-> (s.mode == cfs_pkg::CFS_M_PUP ?
      O_ADDR == $past(O_ADDR) + 18'h00001 : O_ADDR == $past(O_ADDR) - 18'h00001);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("bad address step");

  property p_slow_start;
    s.lbits != `CFS_LEN_LOADED && drives && $fell(O_CONFIG_CLOCK) |->
      s.hi_run == `CFS_SLOW_HALF;
  endproperty
  a_slow_start: assert property (p_slow_start) else $error("clock not slow");

  property p_ready;
    s.phase == cfs_pkg::CFS_LOAD && periph && s.rdy && wr_s && !s.wr_q && !s.full
      |=> !O_READY_BUSY;
  endproperty
  a_ready: assert property (p_ready) else $error("busy not shown");

  property p_stage_a;
    $rose(s.stage[0]) |-> $past(go) && $past(s.phase) == cfs_pkg::CFS_LOAD;
  endproperty
  a_stage_a: assert property (p_stage_a) else $error("start-up too early");

  property p_count;
    s.phase == cfs_pkg::CFS_LOAD && !drives && config_clock_s && !s.config_clock_q && !go
      |=> s.cnt == $past(s.cnt) + 24'h000001;
  endproperty
  a_count: assert property (p_count) else $error("clock not counted");

  property p_sync_hold;
    s.ctl[`CFS_C_DSYNC] && !done_s && !s.stage[3] |=> !s.stage[3];
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("stall ignored");

  property p_done_full;
    $rose(O_DONE_OE_B) |-> mem_full;
  endproperty
  a_done_full: assert property (p_done_full) else $error("done before full");

  property p_user_pin;
    !O_USER_MID_OE_B |-> s.phase == cfs_pkg::CFS_USER;
  endproperty
  a_user_pin: assert property (p_user_pin) else $error("mode pin driven early");

  property p_wait;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST ##1
      O_AVS_WAITREQUEST;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");

  c_load: cover property (s.phase == cfs_pkg::CFS_LOAD ##[1:1000] go);
  c_user: cover property ($rose(s.phase == cfs_pkg::CFS_USER));
  c_stall: cover property (s.ctl[`CFS_C_DSYNC] && !done_s && s.stage[2] && !s.stage[3]);
endmodule : cfs_loader

//--- tb/cfs_src_model.sv
// Serial configuration source: drives the link clock and data bits.
// Assumes the bench starts a burst only after the device's init level is high.
`timescale 1ns/1ps
module cfs_src_model (
  // Burst request from the bench
  input wire logic i_go,
  input wire logic [63:0] i_bits,
  input wire logic [6:0] i_count,
  // Link toward the device
  output logic o_config_clock,
  output logic o_din,
  output logic o_busy
);
  // One burst per request; the clock stands low between bursts
  initial begin
    o_config_clock = 1'b0;
    o_din = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_go);
      o_busy = 1'b1;
      #3;
      for (int k = 0; k < 64; k++) begin
        if (k < i_count) begin
          // Bit set up half a period before the rise, msb first
          o_din = i_bits[63 - k];
          #80 o_config_clock = 1'b1;
          #80 o_config_clock = 1'b0;
        end
      end
      // Released data line shows the inverse of the last bit
      o_din = ~o_din;
      o_busy = 1'b0;
    end
  end
endmodule : cfs_src_model

//--- tb/tb.sv
// Self-checking bench of the configuration loader in serial, master and peripheral modes.
// Assumes the serial source model and a 125 MHz clock; registers via Avalon-MM.
`timescale 1ns/1ps
module tb;
  // Bench-driven inputs
  logic clk, rst_b, init, m_hi, m_mid, m_lo, go, ext_hold, uclk;
  logic [3:0] avs_addr;
  logic avs_rd, avs_wr;
  logic [31:0] avs_wdata;
  logic [63:0] src_bits;
  logic [6:0] src_cnt;
  logic host_wr;
  logic [7:0] host_data;
  // Design outputs and wired pins
  logic o_config_clock, o_config_clock_oe_b, o_ready, o_done, o_done_oe_b, o_io_active, o_gsr;
  logic o_mid, o_mid_oe_b, o_wait, src_config_clock, src_din, busy;
  logic [17:0] o_addr;
  logic [31:0] o_rdata;
  wire config_clock_pin = o_config_clock_oe_b ? src_config_clock : o_config_clock;
  wire done_pin = (o_done_oe_b | o_done) & ~ext_hold;
  wire mid_pin = o_mid_oe_b ? m_mid : o_mid;
  // Counters and event times
  int error_cnt, checks, cyc, t_done, t_io, t_gsr;

  cfs_loader #(.MEM_BITS(16)) cfs_loader_inst (.I_CLOCK(clk), .I_RST_B(rst_b),
    .I_MODE_SELECT_HI(m_hi), .I_MODE_SELECT_MID(mid_pin), .I_MODE_SELECT_LO(m_lo),
    .I_CONFIG_CLOCK(config_clock_pin), .O_CONFIG_CLOCK(o_config_clock), .O_CONFIG_CLOCK_OE_B(o_config_clock_oe_b),
    .I_DIN(src_din), .I_DATA(host_data), .I_HOST_WR(host_wr), .I_INIT(init), .O_ADDR(o_addr),
    .O_READY_BUSY(o_ready), .I_DONE(done_pin), .O_DONE(o_done), .O_DONE_OE_B(o_done_oe_b),
    .I_USER_STARTUP_CLOCK(uclk), .O_IO_ACTIVE(o_io_active), .O_GSR(o_gsr),
    .O_USER_MID(o_mid), .O_USER_MID_OE_B(o_mid_oe_b), .I_AVS_ADDRESS(avs_addr),
    .I_AVS_READ(avs_rd), .I_AVS_WRITE(avs_wr), .I_AVS_WRITEDATA(avs_wdata),
    .O_AVS_READDATA(o_rdata), .O_AVS_WAITREQUEST(o_wait));

  cfs_src_model cfs_src_model_inst (.i_go(go), .i_bits(src_bits), .i_count(src_cnt),
    .o_config_clock(src_config_clock), .o_din(src_din), .o_busy(busy));

  // System clock and a free-running user start-up clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    uclk = 1'b0;
    forever #100 uclk = ~uclk;
  end

  // Cycle stamps of the three start-up events
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst_b) begin
      t_done <= 0;
      t_io <= 0;
      t_gsr <= 0;
    end else begin
      if (o_done_oe_b === 1'b1 && t_done == 0) t_done <= cyc;
      if (o_io_active === 1'b1 && t_io == 0) t_io <= cyc;
      if (o_gsr === 1'b0 && t_gsr == 0) t_gsr <= cyc;
    end
  end

  // Prints counts and the verdict, then ends the run
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // A wait that ran out ends the run as a mismatch
  task timeout_hit(input string what);
    error_cnt++;
    $display("wrong value %s expected handshake seen timeout", what);
    give_verdict;
  endtask : timeout_hit

  // One comparison
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One Avalon-MM access, held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    avs_addr <= a;
    avs_wdata <= wd;
    avs_wr <= wr;
    avs_rd <= ~wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (o_wait !== 1'b0 && k < 50);
    rd = o_rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    if (k >= 50) timeout_hit("bus");
    @(posedge clk);
  endtask : bus

  // Reset with the given mode, then raise init
  task do_reset(input logic [2:0] m);
    @(posedge clk);
    rst_b <= 1'b0;
    init <= 1'b0;
    {m_hi, m_mid, m_lo} <= m;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    init <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset

  // One burst from the source, bounded
  task send(input logic [63:0] b, input logic [6:0] n);
    int k;
    src_bits <= b;
    src_cnt <= n;
    go <= 1'b1;
    k = 0;
    @(posedge clk);
    while (busy !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    go <= 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 2000) timeout_hit("burst");
    repeat (8) @(posedge clk);
  endtask : send

  // Slave serial load: length field then 16 memory bits
  task run_load(input logic [9:0] ctrl, input logic [23:0] len, input logic [6:0] n);
    logic [31:0] d;
    do_reset(3'h7);
    bus(1'b1, 4'h0, {22'h0, ctrl}, d);
    send({len, 16'hc3a5, 24'h5a5a5a}, n);
  endtask : run_load

  task t_regs;
    logic [31:0] d;
    do_reset(3'h7);
    bus(1'b0, 4'h0, 32'h0, d);
    chk("ctrl reset", 32'h1a0, d);
    bus(1'b0, 4'h1, 32'h0, d);
    chk("unmapped", 32'h0, d);
    bus(1'b1, 4'h4, 32'hffffffff, d);
    bus(1'b0, 4'h4, 32'h0, d);
    chk("status mode", 32'h7, {29'h0, d[2:0]});
    chk("done drive level", 32'h0, {31'h0, o_done});
    $display("test registers done");
  endtask : t_regs

  task t_modes;
    logic [31:0] d;
    int k;
    int hi;
    for (int m = 0; m < 8; m++) begin
      do_reset(3'(m));
      bus(1'b0, 4'h4, 32'h0, d);
      chk("mode", 32'(m), {29'h0, d[2:0]});
      if (m != 1) chk("clock drive", {31'h0, !(m == 0 || m == 4 || m == 5 || m == 6)},
        {31'h0, o_config_clock_oe_b});
      if (m == 4) chk("address up", 32'h0, {14'h0, o_addr});
      if (m == 6) chk("address down", 32'h3ffff, {14'h0, o_addr});
      if (m == 0) begin
        // Let the high phase in progress end, then time one whole high phase
        k = 0;
        while (o_config_clock !== 1'b0 && k < 300) begin
          @(posedge clk);
          k++;
        end
        while (o_config_clock !== 1'b1 && k < 300) begin
          @(posedge clk);
          k++;
        end
        if (k >= 300) timeout_hit("clock edge");
        hi = 0;
        while (o_config_clock === 1'b1 && hi < 300) begin
          @(posedge clk);
          hi++;
        end
        chk("slow high time", 32'd62, 32'(hi));
      end
    end
    $display("test modes done");
  endtask : t_modes

  task t_exact;
    logic [31:0] d;
    run_load(10'h3a0, 24'd40, 7'd40);
    bus(1'b0, 4'h8, 32'h0, d);
    chk("clock count", 32'd40, d);
    bus(1'b0, 4'hc, 32'h0, d);
    chk("length", 32'd40, d);
    chk("done held", 32'h0, {31'h0, o_done_oe_b});
    send(64'h0, 7'd8);
    chk("done released", 32'h1, {31'h0, o_done_oe_b});
    chk("io active", 32'h1, {31'h0, o_io_active});
    chk("gsr ended", 32'h0, {31'h0, o_gsr});
    chk("event order", 32'h1, {31'h0, (t_done < t_io) && (t_io < t_gsr)});
    chk("user mid pin", 32'h1, {30'h0, o_mid_oe_b, o_mid});
    bus(1'b0, 4'h4, 32'h0, d);
    chk("stages", 32'h1f, {27'h0, d[7:3]});
    $display("test exact length done");
  endtask : t_exact

  task t_mismatch;
    logic [31:0] d;
    run_load(10'h1a0, 24'd39, 7'd48);
    chk("done kept low", 32'h0, {31'h0, o_done_oe_b});
    chk("gsr held", 32'h1, {31'h0, o_gsr});
    bus(1'b0, 4'h8, 32'h0, d);
    chk("count runs on", 32'd48, d);
    $display("test length mismatch done");
  endtask : t_mismatch

  task t_uclk;
    ext_hold <= 1'b1;
    run_load(10'h1a6, 24'd40, 7'd41);
    repeat (150) @(posedge clk);
    chk("own done released", 32'h1, {31'h0, o_done_oe_b});
    chk("io on user clock", 32'h1, {31'h0, o_io_active});
    chk("gsr stalled", 32'h1, {31'h0, o_gsr});
    ext_hold <= 1'b0;
    repeat (150) @(posedge clk);
    chk("gsr after release", 32'h0, {31'h0, o_gsr});
    $display("test user clock done");
  endtask : t_uclk

  // Peripheral load: host bytes behind the ready flag, each shifted by eight link clocks
  task t_periph(input logic [2:0] m, input int nbytes);
    logic [39:0] stream;
    stream = 40'h000028c3a5;
    do_reset(m);
    for (int b = nbytes - 1; b >= 0; b--) begin
      chk("ready before byte", 32'h1, {31'h0, o_ready});
      host_data <= stream[8*b +: 8];
      host_wr <= 1'b1;
      repeat (5) @(posedge clk);
      chk("busy after byte", 32'h0, {31'h0, o_ready});
      host_wr <= 1'b0;
      send(64'h0, 7'd8);
    end
    send(64'h0, 7'd8);
    chk("peripheral done released", 32'h1, {31'h0, o_done_oe_b});
    $display("test peripheral mode %0d done", m);
  endtask : t_periph

  // Main sequence
  initial begin
    rst_b = 1'b0;
    init = 1'b0;
    {m_hi, m_mid, m_lo} = 3'h7;
    go = 1'b0;
    ext_hold = 1'b0;
    avs_addr = 4'h0;
    avs_rd = 1'b0;
    avs_wr = 1'b0;
    avs_wdata = 32'h0;
    src_bits = 64'h0;
    src_cnt = 7'h0;
    host_wr = 1'b0;
    host_data = 8'h00;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    t_regs;
    t_modes;
    t_exact;
    t_mismatch;
    t_uclk;
    t_periph(3'h3, 5);
    t_periph(3'h2, 2);
    give_verdict;
  end
endmodule : tb
